// file: fpss_pkg.sv
/*
 * constants, codes and carrier types for the flash sequencing host.
 * assumes a 250 MHz single clock and an external parallel flash
 * whose strobes are driven from flip-flops of this block.
 */
`default_nettype none

package fpss_pkg;
    // clock and strobe timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int STROBE_NS = 100;
    localparam int RECOVER_NS = 40;
    localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1)
                                / CLK_PERIOD_PS;
    localparam int RECOVER_CYC = (RECOVER_NS * 1000 + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
    localparam int CNT_W = 8;

    // flash bus widths
    localparam int FL_ADDR_W = 20;
    localparam int FL_DATA_W = 16;

    // flash command codes
    localparam logic [7:0] CODE_PROGRAM = 8'h40;
    localparam logic [7:0] CODE_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CODE_CONFIRM = 8'hD0;
    localparam logic [7:0] CODE_SUSPEND = 8'hB0;
    localparam logic [7:0] CODE_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CODE_CLEAR_DEFAULT = 8'h50;

    // flash status bit positions
    localparam int SR_READY = 7;
    localparam int SR_SUSP = 6;
    localparam int SR_ERASE_ERR = 5;
    localparam int SR_PROG_ERR = 4;
    localparam int SR_VPP_LOW = 3;

    // software register offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam logic [7:0] REG_CTRL = 8'h14;

    // control register fields and reset
    localparam int CTRL_DEFER_BIT = 0;
    localparam int CTRL_PWRDN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // status register layout above the flash status byte
    localparam int ST_BUSY = 8;
    localparam int ST_SUSP = 9;
    localparam int ST_ERR_PEND = 10;
    localparam int ST_REFUSED = 11;
    localparam int ST_ERRS_LSB = 12;
    localparam int ST_ARRAY = 15;

    // software operations written to the command register
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_PROGRAM = 3'h1,
        OP_ERASE = 3'h2,
        OP_SUSPEND = 3'h3,
        OP_RESUME = 3'h4,
        OP_READ = 3'h5,
        OP_CLEAR = 3'h6,
        OP_CHECK = 3'h7
    } fpss_op_e;

    // one flash bus cycle request
    typedef struct packed {
        logic wr;
        logic [FL_ADDR_W-1:0] addr;
        logic [FL_DATA_W-1:0] data;
    } fpss_req_s;

    // flash pins driven by the host
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [FL_ADDR_W-1:0] addr;
        logic [FL_DATA_W-1:0] dq_o;
        logic dq_oe;
    } fpss_pins_s;
endpackage

`default_nettype wire

// file: fpss_bus_cycle.sv
/*
 * one asynchronous flash read or write cycle per request.
 * assumes the flash answers within the strobe time; every cycle
 * ends with chip enable and both strobes high again.
 */
`default_nettype none

module fpss_bus_cycle
    import fpss_pkg::*;
#(
    parameter int ACT_CYC = STROBE_CYC,
    parameter int REC_CYC = RECOVER_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic req_valid,
    input wire fpss_req_s req,
    output logic req_ready,
    output logic done,
    output logic [FL_DATA_W-1:0] rd_data,
    output fpss_pins_s pins,
    input wire logic [FL_DATA_W-1:0] dq_i
);
    typedef enum logic [2:0] {
        B_IDLE = 3'b001,
        B_ACT = 3'b010,
        B_REC = 3'b100
    } fpss_bstate_e;

    fpss_bstate_e state_ff; // cycle phase
    logic [CNT_W-1:0] cnt_ff; // phase countdown
    logic wr_ff; // cycle is a write
    logic [FL_DATA_W-1:0] rd_data_ff; // sampled read data
    fpss_pins_s pins_ff; // registered pins
    logic accept; // request taken

    assign req_ready = (state_ff == B_IDLE);
    assign accept = req_valid && req_ready;
    assign done = (state_ff == B_REC) && (cnt_ff == '0);
    assign rd_data = rd_data_ff;
    assign pins = pins_ff;

    // phase sequencing and countdown
    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= B_IDLE;
            cnt_ff <= '0;
            wr_ff <= 1'b0;
        end else begin
            case (state_ff)
                B_IDLE: begin
                    if (accept) begin
                        state_ff <= B_ACT;
                        cnt_ff <= CNT_W'(ACT_CYC - 1);
                        wr_ff <= req.wr;
                    end
                end
                B_ACT: begin
                    if (cnt_ff == '0) begin
                        state_ff <= B_REC;
                        cnt_ff <= CNT_W'(REC_CYC - 1);
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                B_REC: begin
                    if (cnt_ff == '0) begin
                        state_ff <= B_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                default: begin
                    state_ff <= B_IDLE;
                end
            endcase
        end
    end

    // strobes: ce_n and the read or write strobe low in active phase, all high through recovery
    always_ff @(posedge clk) begin
        if (srst) begin
            pins_ff <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                         addr: '0, dq_o: '0, dq_oe: 1'b0};
        end else if (accept) begin
            pins_ff.ce_n <= 1'b0;
            pins_ff.we_n <= !req.wr;
            pins_ff.oe_n <= req.wr;
            pins_ff.addr <= req.addr;
            pins_ff.dq_o <= req.data;
            pins_ff.dq_oe <= req.wr;
        end else if (state_ff == B_ACT && cnt_ff == '0) begin
            // strobes rise, data held through recovery
            pins_ff.ce_n <= 1'b1;
            pins_ff.we_n <= 1'b1;
            pins_ff.oe_n <= 1'b1;
        end else if (done) begin
            pins_ff.dq_oe <= 1'b0;
        end
    end

    // read data sampled just before the strobes rise
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data_ff <= '0;
        end else if (state_ff == B_ACT && cnt_ff == '0 && !wr_ff) begin
            rd_data_ff <= dq_i;
        end
    end

    // every completed cycle has released the chip between accesses
    a_strobe_toggle: assert property (@(posedge clk) disable iff (srst)
        done |-> pins_ff.ce_n && pins_ff.oe_n && pins_ff.we_n)
        else $error("strobes still low at cycle end");
endmodule

`default_nettype wire

// file: fpss_host.sv
/*
 * host sequencer for a parallel flash: program, block erase,
 * suspend/resume, array read and status clear, ordered through a
 * small software register port. assumes one flash on the pins and
 * software that polls the busy bit before the next order.
 */
`default_nettype none

// Contract
// - program is set-up code, then address/data
// - poll status, strobes toggled, until ready
// - error check per word or per sequence
// - clear flags before further operations
// - suspend code written, status then read
// - read-array code before reading other blocks
// - resume code continues suspended erase
// - erase is set-up code, then confirm
module fpss_host
    import fpss_pkg::*;
#(
    parameter logic [7:0] CLEAR_CODE = CODE_CLEAR_DEFAULT
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output fpss_pins_s flash_pins,
    input wire logic [FL_DATA_W-1:0] flash_dq_i,
    output logic powerdown_unlock_pin_n
);
    typedef enum logic [10:0] {
        S_IDLE = 11'b000_0000_0001,
        S_PG_SET = 11'b000_0000_0010,
        S_PG_DAT = 11'b000_0000_0100,
        S_ER_SET = 11'b000_0000_1000,
        S_ER_CONF = 11'b000_0001_0000,
        S_SUS = 11'b000_0010_0000,
        S_RES = 11'b000_0100_0000,
        S_RA = 11'b000_1000_0000,
        S_RD = 11'b001_0000_0000,
        S_POLL = 11'b010_0000_0000,
        S_CLR = 11'b100_0000_0000
    } fpss_state_e;

    typedef enum logic [1:0] {
        K_PROG = 2'h0,
        K_ERASE = 2'h1,
        K_SUSP = 2'h2
    } fpss_kind_e;

    fpss_state_e state_ff; // sequencer state
    fpss_kind_e kind_ff; // what the poll waits for
    logic issued_ff; // bus cycle of this state in flight
    logic [FL_ADDR_W-1:0] addr_ff; // target address
    logic [FL_DATA_W-1:0] wdata_ff; // program data
    logic [1:0] ctrl_ff; // defer check, power down
    logic [7:0] fstat_ff; // last flash status byte
    logic [FL_DATA_W-1:0] rdata_ff; // last array read
    logic susp_ff; // erase held suspended
    logic susp_req_ff; // suspend asked during erase poll
    logic err_pend_ff; // error seen, clear needed
    logic [2:0] errs_ff; // sticky erase, program, supply errors
    logic refused_ff; // last order refused
    logic array_ff; // flash believed in array read mode
    logic [31:0] reg_rdata_ff; // read data register

    fpss_req_s req; // request to the bus engine
    logic req_valid; // request offered
    logic req_ready; // engine idle
    logic bus_done; // bus cycle finished
    logic [FL_DATA_W-1:0] bus_rd; // bus read data
    logic cmd_wr; // command register written
    fpss_op_e op; // order written
    logic ok; // order accepted
    logic [2:0] new_errs; // errors in status just read

    assign cmd_wr = reg_wr && (reg_addr == REG_CMD);
    assign op = fpss_op_e'(reg_wdata[2:0]);
    assign new_errs = {bus_rd[SR_ERASE_ERR], bus_rd[SR_PROG_ERR],
                       bus_rd[SR_VPP_LOW]};
    assign powerdown_unlock_pin_n = !ctrl_ff[CTRL_PWRDN_BIT];
    assign reg_rdata = reg_rdata_ff;

    // acceptance of an order in the present state
    always_comb begin
        ok = 1'b0;
        if (cmd_wr && !ctrl_ff[CTRL_PWRDN_BIT]) begin
            case (op)
                OP_PROGRAM, OP_ERASE: begin
                    // blocked until flags cleared, or while suspended
                    ok = (state_ff == S_IDLE) && !err_pend_ff
                         && !susp_ff;
                end
                OP_SUSPEND: begin
                    ok = (state_ff == S_POLL) && (kind_ff == K_ERASE);
                end
                OP_RESUME: begin
                    ok = (state_ff == S_IDLE) && susp_ff;
                end
                OP_READ, OP_CHECK: begin
                    ok = (state_ff == S_IDLE);
                end
                OP_CLEAR: begin
                    // suspended flash takes only read-array or resume
                    ok = (state_ff == S_IDLE) && !susp_ff;
                end
                default: begin
                    ok = 1'b0;
                end
            endcase
        end
    end

    // bus request for the present state
    always_comb begin
        req = '{wr: 1'b1, addr: addr_ff, data: '0};
        case (state_ff)
            S_PG_SET: req.data = FL_DATA_W'(CODE_PROGRAM);
            S_PG_DAT: req.data = wdata_ff;
            S_ER_SET: req.data = FL_DATA_W'(CODE_ERASE_SETUP);
            S_ER_CONF: req.data = FL_DATA_W'(CODE_CONFIRM);
            S_SUS: req.data = FL_DATA_W'(CODE_SUSPEND);
            S_RES: req.data = FL_DATA_W'(CODE_CONFIRM);
            S_RA: req.data = FL_DATA_W'(CODE_READ_ARRAY);
            S_CLR: req.data = FL_DATA_W'(CLEAR_CODE);
            S_RD, S_POLL: req.wr = 1'b0;
            default: req.wr = 1'b0;
        endcase
    end
    assign req_valid = (state_ff != S_IDLE) && !issued_ff;

    fpss_bus_cycle u_bus (
        .clk(clk),
        .srst(srst),
        .req_valid(req_valid),
        .req(req),
        .req_ready(req_ready),
        .done(bus_done),
        .rd_data(bus_rd),
        .pins(flash_pins),
        .dq_i(flash_dq_i)
    );

    // one bus cycle per state visit, re-armed on completion
    always_ff @(posedge clk) begin
        if (srst) begin
            issued_ff <= 1'b0;
        end else if (bus_done) begin
            issued_ff <= 1'b0;
        end else if (req_valid && req_ready) begin
            issued_ff <= 1'b1;
        end
    end

    // sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= S_IDLE;
            kind_ff <= K_PROG;
        end else if (state_ff == S_IDLE) begin
            if (ok) begin
                case (op)
                    OP_PROGRAM: state_ff <= S_PG_SET;
                    OP_ERASE: state_ff <= S_ER_SET;
                    OP_RESUME: state_ff <= S_RES;
                    // array mode must be entered before reading
                    OP_READ: state_ff <= array_ff ? S_RD : S_RA;
                    OP_CLEAR: state_ff <= S_CLR;
                    default: state_ff <= S_IDLE;
                endcase
            end
        end else if (bus_done) begin
            case (state_ff)
                S_PG_SET: state_ff <= S_PG_DAT;
                S_PG_DAT: begin
                    // flash now answers with status
                    state_ff <= S_POLL;
                    kind_ff <= K_PROG;
                end
                S_ER_SET: state_ff <= S_ER_CONF;
                S_ER_CONF, S_RES: begin
                    state_ff <= S_POLL;
                    kind_ff <= K_ERASE;
                end
                S_SUS: begin
                    state_ff <= S_POLL;
                    kind_ff <= K_SUSP;
                end
                S_RA: state_ff <= S_RD;
                S_POLL: begin
                    // keep reading until the ready bit is one, or go to suspend if asked during erase
                    if (bus_rd[SR_READY]) begin
                        state_ff <= S_IDLE;
                    end else if (susp_req_ff && kind_ff == K_ERASE) begin
                        state_ff <= S_SUS;
                    end
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    // suspend bookkeeping
    always_ff @(posedge clk) begin
        if (srst) begin
            susp_ff <= 1'b0;
            susp_req_ff <= 1'b0;
        end else begin
            if (ok && op == OP_SUSPEND) begin
                susp_req_ff <= 1'b1;
            end else if (state_ff == S_SUS) begin
                susp_req_ff <= 1'b0;
            end
            if (state_ff == S_POLL && bus_done && bus_rd[SR_READY]
                && kind_ff == K_SUSP) begin
                // one: held suspended, zero: erase had finished
                susp_ff <= bus_rd[SR_SUSP];
            end else if (state_ff == S_RES && bus_done) begin
                susp_ff <= 1'b0;
            end
        end
    end

    // error flags; clear only in the clear state, sets in poll or on a check order
    always_ff @(posedge clk) begin
        if (srst) begin
            errs_ff <= '0;
            err_pend_ff <= 1'b0;
        end else if (state_ff == S_POLL && bus_done && bus_rd[SR_READY]
                     && !(kind_ff == K_SUSP && bus_rd[SR_SUSP])) begin
            errs_ff <= errs_ff | new_errs;
            if (!ctrl_ff[CTRL_DEFER_BIT] && new_errs != '0) begin
                err_pend_ff <= 1'b1;
            end
        end else if (ok && op == OP_CHECK && errs_ff != '0) begin
            err_pend_ff <= 1'b1;
        end else if (state_ff == S_CLR && bus_done) begin
            errs_ff <= '0;
            err_pend_ff <= 1'b0;
        end
    end

    // flash read mode tracking and captured bytes
    always_ff @(posedge clk) begin
        if (srst) begin
            array_ff <= 1'b1;
            fstat_ff <= '0;
            rdata_ff <= '0;
        end else begin
            if (ctrl_ff[CTRL_PWRDN_BIT]) begin
                array_ff <= 1'b1;
            end else if (bus_done && state_ff == S_RA) begin
                array_ff <= 1'b1;
            end else if (bus_done && req.wr) begin
                array_ff <= 1'b0;
            end
            if (bus_done && state_ff == S_POLL) begin
                fstat_ff <= bus_rd[7:0];
            end
            if (bus_done && state_ff == S_RD) begin
                rdata_ff <= bus_rd;
            end
        end
    end

    // software registers: address, data, control, refusal flag
    always_ff @(posedge clk) begin
        if (srst) begin
            addr_ff <= '0;
            wdata_ff <= '0;
            ctrl_ff <= CTRL_RESET;
            refused_ff <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == REG_ADDR) begin
                addr_ff <= reg_wdata[FL_ADDR_W-1:0];
            end
            if (reg_addr == REG_WDATA) begin
                wdata_ff <= reg_wdata[FL_DATA_W-1:0];
            end
            if (reg_addr == REG_CTRL) begin
                ctrl_ff <= reg_wdata[1:0];
            end
            if (cmd_wr) begin
                refused_ff <= !ok;
            end
        end
    end

    // read port, data in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata_ff <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_ADDR: reg_rdata_ff <= 32'(addr_ff);
                REG_WDATA: reg_rdata_ff <= 32'(wdata_ff);
                REG_STATUS: reg_rdata_ff <= {16'h0000, array_ff, errs_ff,
                    refused_ff, err_pend_ff, susp_ff,
                    state_ff != S_IDLE, fstat_ff};
                REG_RDATA: reg_rdata_ff <= 32'(rdata_ff);
                REG_CTRL: reg_rdata_ff <= 32'(ctrl_ff);
                default: reg_rdata_ff <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_ff <= 32'h0000_0000;
        end
    end

    a_pg_setup_code: assert property (@(posedge clk) disable iff (srst)
        state_ff == S_PG_SET && req_valid && req_ready
        |-> req.wr && req.data == FL_DATA_W'(CODE_PROGRAM)
        ##1 (state_ff == S_PG_SET) [*1])
        else $error("program set-up code not driven");
    a_pg_then_poll: assert property (@(posedge clk) disable iff (srst)
        state_ff == S_PG_DAT && bus_done |=> state_ff == S_POLL
        && kind_ff == K_PROG)
        else $error("program data not followed by status poll");
    a_poll_busy: assert property (@(posedge clk) disable iff (srst)
        state_ff == S_POLL && bus_done && !bus_rd[SR_READY]
        && !susp_req_ff |=> state_ff == S_POLL && req_valid)
        else $error("poll stopped while busy");
    a_err_blocks: assert property (@(posedge clk) disable iff (srst)
        err_pend_ff && cmd_wr && (op == OP_PROGRAM || op == OP_ERASE)
        |=> state_ff == $past(state_ff) && refused_ff)
        else $error("operation started with error pending");
    a_susp_code: assert property (@(posedge clk) disable iff (srst)
        state_ff == S_SUS && req_valid && req_ready
        |-> req.data == FL_DATA_W'(CODE_SUSPEND))
        else $error("suspend code not driven");
    a_read_array: assert property (@(posedge clk) disable iff (srst)
        $rose(state_ff == S_RD) |-> $past(array_ff) || $past(state_ff
        == S_RA))
        else $error("array read without read-array code");
    a_resume_clear: assert property (@(posedge clk) disable iff (srst)
        state_ff == S_RES && bus_done |=> !susp_ff && state_ff == S_POLL
        && kind_ff == K_ERASE)
        else $error("resume did not restart erase poll");
    a_clear_flags: assert property (@(posedge clk) disable iff (srst)
        state_ff == S_CLR && bus_done |=> errs_ff == '0 && !err_pend_ff
        && state_ff == S_IDLE)
        else $error("flags not cleared after clear code");
endmodule

`default_nettype wire

// file: fpss_flash_model.sv
/*
 * behavioural parallel flash answering the host's strobes.
 * assumes strobes from flip-flops on clk; busy time in clk cycles.
 */
`default_nettype none

module fpss_flash_model
    import fpss_pkg::*;
#(
    parameter int PROG_CYC = 20,
    parameter int ERASE_CYC = 600
) (
    input wire logic clk,
    input wire fpss_pins_s pins,
    input wire logic [15:0] dq_in,
    input wire logic pd_n,
    input wire logic fail,
    output logic [15:0] dq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0;
    logic [7:0] pend = 8'h0;
    logic [2:0] err = 3'h0; // erase, program, supply
    logic we_q = 1'b1;
    logic st_mode = 1'b0;
    logic susp = 1'b0;
    logic erasing = 1'b0;
    int busy = 0;
    logic [7:0] c;
    // ready also while suspended
    wire [7:0] sr = {busy == 0 || susp, susp, err, 3'h0};
    wire rd_on = !pins.ce_n && !pins.oe_n;
    // released bus shows inverse of last value
    assign dq_out = rd_on ? (st_mode ? {8'h0, sr} : mem[pins.addr[3:0]])
                          : ~last;
    initial for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
    // command decode at the end of each write strobe
    always @(posedge clk) begin
        c = dq_in[7:0];
        we_q <= pins.we_n;
        if (rd_on) last <= dq_out;
        if (busy > 0 && !susp) busy <= busy - 1;
        if (!pd_n) begin
            st_mode <= 1'b0;
            err <= 3'h0;
            susp <= 1'b0;
            busy <= 0;
            pend <= 8'h0;
        end else if (!we_q && pins.we_n) begin
            pend <= 8'h0;
            if (pend == CODE_PROGRAM) begin
                if (fail) err[1] <= 1'b1;
                else mem[pins.addr[3:0]] <= mem[pins.addr[3:0]] & dq_in;
                busy <= PROG_CYC;
                erasing <= 1'b0;
                st_mode <= 1'b1;
            end else if (pend == CODE_ERASE_SETUP && c == CODE_CONFIRM) begin
                for (int i = 0; i < 8; i++) mem[{pins.addr[3], 3'(i)}] <= '1;
                busy <= ERASE_CYC;
                erasing <= 1'b1;
                st_mode <= 1'b1;
            end else if (busy != 0 && !susp) begin
                if (c == CODE_SUSPEND && erasing) susp <= 1'b1;
            end else if (susp) begin
                if (c == CODE_CONFIRM) susp <= 1'b0;
                if (c == CODE_CONFIRM) st_mode <= 1'b1;
                if (c == CODE_READ_ARRAY) st_mode <= 1'b0;
            end else if (c == CODE_PROGRAM || c == CODE_ERASE_SETUP) pend <= c;
            else if (c == CODE_READ_ARRAY) st_mode <= 1'b0;
            else if (c == CODE_CLEAR_DEFAULT) err <= 3'h0;
        end // other cycles keep state
    end
endmodule

`default_nettype wire

// file: tb_top.sv
/*
 * self-checking bench for the flash host with a flash model.
 * assumes the register port contract and 250 MHz clock.
 */
`default_nettype none

`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fpss_pkg::*;
    typedef struct {logic [2:0] op; logic [19:0] a; logic [15:0] d;
        logic [7:0] r; logic [31:0] e;} fpss_row_s;
    logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, fail = 0;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, st;
    logic [15:0] fl_q, bus;
    logic pd_n;
    fpss_pins_s pins;
    int compares = 0, miscompares = 0;
    fpss_row_s rows [4] = '{'{OP_PROGRAM, 1, 16'h1234, REG_STATUS, 32'h80},
        '{OP_READ, 1, 0, REG_RDATA, 32'h1234},
        '{OP_ERASE, 1, 0, REG_STATUS, 32'h80},
        '{OP_READ, 1, 0, REG_RDATA, 32'hFFFF}};
    // resolved data bus
    assign bus = pins.dq_oe ? pins.dq_o : fl_q;
    always #2 clk = ~clk;
    fpss_host i_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .flash_pins(pins), .flash_dq_i(bus),
        .powerdown_unlock_pin_n(pd_n));
    fpss_flash_model i_flash (.clk(clk), .pins(pins), .dq_in(bus),
        .pd_n(pd_n), .fail(fail), .dq_out(fl_q));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
        @(posedge clk); reg_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk); reg_addr <= a; reg_rd <= 1;
        @(posedge clk); reg_rd <= 0;
        #1 d = reg_rdata;
    endtask
    // poll the busy bit, bounded
    task automatic idle;
        repeat (3) @(posedge clk);
        for (int n = 0; n < 1000; n++) begin
            rd(REG_STATUS, st);
            if (st[ST_BUSY] === 1'b0) break;
        end
    endtask
    task automatic op(input logic [2:0] o, input logic [19:0] a,
                      input logic [15:0] d);
        wr(REG_ADDR, 32'(a)); wr(REG_WDATA, 32'(d)); wr(REG_CMD, 32'(o));
        idle();
    endtask
    task automatic close_out;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (50000) @(posedge clk);
        miscompares++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge clk); srst <= 0;
        rd(REG_STATUS, st); `CHK(st, 32'h8000)
        `CHK(pins.ce_n, 1'b1)
        rd(8'h20, st); `CHK(st, 32'h0)
        $display("reset test done");
        foreach (rows[i]) begin
            op(rows[i].op, rows[i].a, rows[i].d);
            rd(rows[i].r, st); `CHK(st, rows[i].e)
            $display("row %0d done", i);
        end
        fail <= 1;
        op(OP_PROGRAM, 1, 16'h5678); fail <= 0;
        `CHK(st, 32'h2490)
        op(OP_PROGRAM, 1, 16'h5678);
        `CHK(st[11:10], 2'h3)
        op(OP_CLEAR, 0, 0); op(OP_PROGRAM, 1, 16'h5678);
        `CHK(st, 32'h80)
        $display("error test done");
        wr(REG_ADDR, 32'h8); wr(REG_CMD, 32'(OP_ERASE));
        repeat (200) @(posedge clk);
        wr(REG_CMD, 32'(OP_SUSPEND)); idle();
        `CHK(st, 32'h2C0)
        op(OP_READ, 1, 0); rd(REG_RDATA, st); `CHK(st, 32'h5678)
        op(OP_RESUME, 0, 0); `CHK(st, 32'h80)
        op(OP_READ, 8, 0); rd(REG_RDATA, st); `CHK(st, 32'hFFFF)
        $display("suspend test done");
        wr(REG_CTRL, 32'h2); repeat (2) @(posedge clk);
        `CHK(pd_n, 1'b0)
        rd(REG_STATUS, st); `CHK(st[ST_ARRAY], 1'b1)
        wr(REG_CTRL, 32'h0);
        $display("power down test done");
        // deferred error check: errors latch, pending only on check
        wr(REG_CTRL, 32'h1); fail <= 1; op(OP_PROGRAM, 2, 16'h0);
        fail <= 0; `CHK(st[11:10], 2'h0)
        `CHK(st[14:12], 3'h2)
        op(OP_CHECK, 0, 0); `CHK(st[11:10], 2'h1)
        op(OP_CLEAR, 0, 0); `CHK(st[14:10], 5'h0)
        wr(REG_CTRL, 32'h0);
        $display("deferred check test done");
        close_out();
    end
endmodule

`default_nettype wire
